// ==== src/pvec_ctrl.sv ====
// preview engine control registers, windowing and pixel path
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - separate enables: interpolation, noise filter, a-law
// - median filter only while its bit set
// - enable write clears one-shot and source
// - one-shot bit: single frame, else continuous
// - source bit: video port or sdram fetch
// - busy reads one while processing a frame
// - enable bit sampled at frame start gates that whole frame
module pvec_ctrl
  import pvec_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // avalon-mm slave
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  // video port pins from the sensor front controller
  input  wire logic [PIX_W-1:0] vp_pix_i,
  input  wire logic             vp_valid_i,
  input  wire logic             vp_line_i,
  input  wire logic             vp_frame_i,
  // sdram frame fetch stream
  input  wire logic [PIX_W-1:0] sd_pix_i,
  input  wire logic             sd_valid_i,
  input  wire logic             sd_line_i,
  input  wire logic             sd_frame_i,
  output logic                  sd_ready_o,
  // processed pixel output
  output logic      [PIX_W-1:0] px_data_o,
  output logic                  px_valid_o,
  input  wire logic             px_ready_i
);
  localparam int SW = PIX_W + 3;

  // ---- bus slave and registers ----
  logic [31:0]       ctrl_q, ctrl_d, horz_q, horz_d, vert_q, vert_d;
  logic [31:0]       rdata_q, rdata_d, wmask;
  logic              wait_q, wait_d, run_os_q, run_os_d;
  logic              run_sd_q, run_sd_d, busy_q, busy_d;
  logic              acc, wr_ctrl, en_set, frame_end;
  logic [WIN_W-1:0]  sp, ep, sl, el;

  assign sp = horz_q[WIN_HI_LSB +: WIN_W];
  assign ep = horz_q[WIN_W-1:0];
  assign sl = vert_q[WIN_HI_LSB +: WIN_W];
  assign el = vert_q[WIN_W-1:0];

  // byte enables to bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
    end
  end

  // access completes on the edge where waitrequest is low
  always_comb begin
    acc     = (avs_read_i || avs_write_i) && !wait_q;
    wait_d  = !((avs_read_i || avs_write_i) && wait_q);
    wr_ctrl = acc && avs_write_i && avs_address_i == OFS_CTRL;
    en_set  = wr_ctrl && avs_byteenable_i[0]
              && avs_writedata_i[B_ENABLE];
    ctrl_d  = ctrl_q;
    horz_d  = horz_q;
    vert_d  = vert_q;
    run_os_d = run_os_q;
    run_sd_d = run_sd_q;
    // one-shot run drops enable at frame end; a write wins
    if (frame_end && run_os_q) begin
      ctrl_d[B_ENABLE] = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d = (ctrl_q & ~wmask) | (avs_writedata_i & wmask);
      ctrl_d[31:CTRL_TOP+1] = '0;
      ctrl_d[B_BUSY] = 1'b0;
    end
    if (en_set) begin
      // mode latched for the run, register bits read back 0
      run_os_d = avs_writedata_i[B_SINGLE_FRAME_MODE];
      run_sd_d = avs_writedata_i[B_SOURCE];
      ctrl_d[B_SINGLE_FRAME_MODE] = 1'b0;
      ctrl_d[B_SOURCE]  = 1'b0;
    end
    if (acc && avs_write_i && avs_address_i == OFS_HORZ) begin
      horz_d = ((horz_q & ~wmask) | (avs_writedata_i & wmask))
               & 32'h3fff_3fff;
    end
    if (acc && avs_write_i && avs_address_i == OFS_VERT) begin
      vert_d = ((vert_q & ~wmask) | (avs_writedata_i & wmask))
               & 32'h3fff_3fff;
    end
    case (avs_address_i)
      OFS_CTRL: begin
        rdata_d = ctrl_q;
        rdata_d[B_BUSY] = busy_q;
      end
      OFS_HORZ: rdata_d = horz_q;
      OFS_VERT: rdata_d = vert_q;
      default:  rdata_d = 32'h0000_0000;
    endcase
    if (!(avs_read_i && wait_q)) begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= CTRL_RST;
      horz_q   <= {2'b00, WIN_RST, 2'b00, WIN_RST};
      vert_q   <= {2'b00, WIN_RST, 2'b00, WIN_RST};
      rdata_q  <= 32'h0000_0000;
      wait_q   <= 1'b1;
      run_os_q <= 1'b0;
      run_sd_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      horz_q   <= horz_d;
      vert_q   <= vert_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      run_os_q <= run_os_d;
      run_sd_q <= run_sd_d;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ---- video port synchroniser ----
  logic [SW-1:0] sy1_q, sy2_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= {vp_frame_i, vp_line_i, vp_valid_i, vp_pix_i};
      sy2_q <= sy1_q;
    end
  end

  // ---- source select and frame tracking ----
  logic [PIX_W-1:0] s_pix;
  logic             s_val, s_line, s_frame;
  logic             line_q, frame_q, act_q, act_d;
  logic             line_rise, frame_rise;

  always_comb begin
    if (run_sd_q) begin
      s_pix   = sd_pix_i;
      s_val   = sd_valid_i && sd_ready_o;
      s_line  = sd_line_i;
      s_frame = sd_frame_i;
    end else begin
      s_pix   = sy2_q[PIX_W-1:0];
      s_val   = sy2_q[PIX_W];
      s_line  = sy2_q[PIX_W+1];
      s_frame = sy2_q[PIX_W+2];
    end
    line_rise  = s_line && !line_q;
    frame_rise = s_frame && !frame_q;
    frame_end  = act_q && !s_frame && frame_q;
    // a frame runs only if enabled at its start
    act_d = act_q;
    if (frame_rise) begin
      act_d = ctrl_q[B_ENABLE];
    end else if (frame_end) begin
      act_d = 1'b0;
    end
    busy_d = act_d;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q  <= 1'b0;
      frame_q <= 1'b0;
      act_q   <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      line_q  <= s_line;
      frame_q <= s_frame;
      act_q   <= act_d;
      busy_q  <= busy_d;
    end
  end

  // ---- stage a: counters, format, window, dark frame ----
  logic [WIN_W-1:0] pcnt_q, pcnt_d, lcnt_q, lcnt_d;
  logic [PIX_W-1:0] fmt, lin, a_pix_q, a_pix_d, dark_q, dark_d;
  logic [14:0]      alaw_sh;
  logic             in_win, a_val_q, a_val_d;

  always_comb begin
    // eight-bit samples sit in the low bits, scaled up
    fmt = ctrl_q[B_WIDTH] ? {s_pix[7:0], 2'b00} : s_pix;
    // segment and mantissa of an eight-bit companded code
    alaw_sh = 15'({1'b1, fmt[6:2]}) << fmt[9:7];
    lin = ctrl_q[B_ALAW] ? alaw_sh[14:5] : fmt;
    in_win = pcnt_q >= sp && pcnt_q <= ep
             && lcnt_q >= sl && lcnt_q <= el;
    pcnt_d = line_rise ? '0 : (s_val ? pcnt_q + 1'b1 : pcnt_q);
    lcnt_d = frame_rise ? '0 : (line_rise ? lcnt_q + 1'b1 : lcnt_q);
    dark_d = dark_q;
    a_val_d = 1'b0;
    a_pix_d = a_pix_q;
    if (act_q && s_val && in_win && !line_rise) begin
      if (ctrl_q[B_DCAP]) begin
        dark_d = lin;
      end else begin
        a_val_d = 1'b1;
        a_pix_d = (ctrl_q[B_DSUB] && lin > dark_q) ? lin - dark_q
                : (ctrl_q[B_DSUB] ? '0 : lin);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcnt_q  <= '0;
      lcnt_q  <= '0;
      dark_q  <= DARK_RST;
      a_val_q <= 1'b0;
      a_pix_q <= '0;
    end else begin
      pcnt_q  <= pcnt_d;
      lcnt_q  <= lcnt_d;
      dark_q  <= dark_d;
      a_val_q <= a_val_d;
      a_pix_q <= a_pix_d;
    end
  end

  // ---- stage b: noise, interpolation, median ----
  logic [PIX_W-1:0] p1_q, p1_d, p2_q, p2_d, nf, cf, md, b_pix_q, b_pix_d;
  logic [PIX_W:0]   sum_n, sum_c;
  logic             b_val_q, b_val_d;

  always_comb begin
    sum_n = {1'b0, a_pix_q} + {1'b0, p1_q};
    sum_c = {1'b0, a_pix_q} + {1'b0, p2_q};
    nf = ctrl_q[B_NOISE] ? sum_n[PIX_W:1] : a_pix_q;
    cf = ctrl_q[B_CFA] ? sum_c[PIX_W:1] : nf;
    // median of current and two previous samples
    // inclusive bounds so equal samples still pick the shared value
    if ((cf >= p1_q && cf <= p2_q) || (cf <= p1_q && cf >= p2_q)) begin
      md = cf;
    end else if ((p1_q >= cf && p1_q <= p2_q)
                 || (p1_q <= cf && p1_q >= p2_q)) begin
      md = p1_q;
    end else begin
      md = p2_q;
    end
    b_pix_d = ctrl_q[B_MEDIAN] ? md : cf;
    b_val_d = a_val_q;
    p1_d = a_val_q ? a_pix_q : p1_q;
    p2_d = a_val_q ? p1_q : p2_q;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_q    <= '0;
      p2_q    <= '0;
      b_pix_q <= '0;
      b_val_q <= 1'b0;
    end else begin
      p1_q    <= p1_d;
      p2_q    <= p2_d;
      b_pix_q <= b_pix_d;
      b_val_q <= b_val_d;
    end
  end

  // ---- output buffer ----
  pvec_strm_if #(.W(PIX_W)) fin_s ();
  pvec_strm_if #(.W(PIX_W)) fout_s ();
  assign fin_s.data   = b_pix_q;
  assign fin_s.valid  = b_val_q;
  assign fout_s.ready = px_ready_i;
  assign sd_ready_o   = fin_s.ready;
  assign px_data_o    = fout_s.data;
  assign px_valid_o   = fout_s.valid;

  pvec_fifo #(
    .W      (PIX_W),
    .D      (FIFO_DEPTH),
    .MARGIN (FIFO_MARGIN)
  ) u_fifo (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .in_s      (fin_s),
    .out_s     (fout_s)
  );

  // ---- checks ----
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  a_bus_answer_one: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) s_req_wait |=> !avs_waitrequest_o ##1
    avs_waitrequest_o) else $error("waitrequest not one-cycle low");
  a_enable_clears_mode: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) en_set |=> !ctrl_q[B_SINGLE_FRAME_MODE]
    && !ctrl_q[B_SOURCE] && ctrl_q[B_ENABLE])
    else $error("enable write left mode bits set");
  a_single_frame_mode_stop: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) frame_end && run_os_q && !wr_ctrl
    |=> !ctrl_q[B_ENABLE]) else $error("one-shot did not stop");
  a_busy_read: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) avs_read_i && wait_q
    && avs_address_i == OFS_CTRL |=> avs_readdata_o[B_BUSY]
    == $past(busy_q)) else $error("busy readback wrong");
  a_disabled_idle: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) frame_rise && !ctrl_q[B_ENABLE]
    |=> !busy_q ##1 !b_val_q) else $error("engine ran disabled");
  a_median_bypass: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) a_val_q && !ctrl_q[B_MEDIAN]
    && !ctrl_q[B_CFA] && !ctrl_q[B_NOISE]
    |=> b_pix_q == $past(a_pix_q)) else $error("bypass altered pixel");
  a_dark_capture: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) ctrl_q[B_DCAP] && $stable(ctrl_q)
    |=> !a_val_q) else $error("pixel passed during dark capture");
  a_narrow_input: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) ctrl_q[B_WIDTH] && !ctrl_q[B_ALAW]
    && !ctrl_q[B_DSUB] && a_val_d |=> a_pix_q[1:0] == 2'b00)
    else $error("narrow pixel not aligned");
  a_sdram_source: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) run_sd_q && !sd_valid_i |-> !s_val)
    else $error("video port used in sdram mode");
endmodule : pvec_ctrl
`default_nettype wire

// ==== src/pvec_fifo.sv ====
// pixel fifo with registered read data and early ready
`timescale 1ns/1ps
`default_nettype none
module pvec_fifo
  import pvec_pkg::*;
#(
  parameter int W      = PIX_W,
  parameter int D      = FIFO_DEPTH,
  parameter int MARGIN = FIFO_MARGIN
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // filling and draining sides
  pvec_strm_if.snk  in_s,
  pvec_strm_if.src  out_s
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          room_q, room_d, ov_q, ov_d;
  logic [W-1:0]  od_q, od_d;
  logic          push, pop;

  assign in_s.ready  = room_q;
  assign out_s.valid = ov_q;
  assign out_s.data  = od_q;

  // pointer, count and output stage next values
  always_comb begin
    push   = in_s.valid && (cnt_q < (AW+1)'(D));
    pop    = (cnt_q != '0) && (!ov_q || out_s.ready);
    wp_d   = push ? wp_q + 1'b1 : wp_q;
    rp_d   = pop ? rp_q + 1'b1 : rp_q;
    cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    room_d = cnt_d <= (AW+1)'(D - MARGIN);
    ov_d   = pop ? 1'b1 : (out_s.ready ? 1'b0 : ov_q);
    od_d   = pop ? mem_q[rp_q] : od_q;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      room_q <= 1'b0;
      ov_q   <= 1'b0;
      od_q   <= '0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      room_q <= room_d;
      ov_q   <= ov_d;
      od_q   <= od_d;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[wp_q] <= in_s.data;
    end
  end
endmodule : pvec_fifo
`default_nettype wire

// ==== src/pvec_pkg.sv ====
// shared constants for the preview engine control block
package pvec_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_HORZ = 4'h4;
  localparam logic [3:0] OFS_VERT = 4'h8;
  // control field positions
  localparam int B_ENABLE   = 0;
  localparam int B_BUSY     = 1;
  localparam int B_SOURCE   = 2;
  localparam int B_SINGLE_FRAME_MODE  = 3;
  localparam int B_WIDTH    = 4;
  localparam int B_ALAW     = 5;
  localparam int B_DSUB     = 6;
  localparam int B_DCAP     = 7;
  localparam int B_MEDIAN   = 8;
  localparam int B_NOISE    = 9;
  localparam int B_CFA      = 10;
  localparam int CTRL_TOP   = 10;
  // window field positions
  localparam int WIN_HI_LSB = 16;
  localparam int WIN_W      = 14;
  // values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [13:0] WIN_RST  = 14'h0000;
  localparam logic [9:0]  DARK_RST = 10'h000;
  // datapath sizes and timing
  localparam int PIX_W       = 10;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_MARGIN = 4;   // in-flight pixels after ready drops
  localparam int SYNC_STAGES = 2;
endpackage : pvec_pkg

// ==== src/pvec_strm_if.sv ====
// pixel stream carrier between the engine and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface pvec_strm_if #(parameter int W = 10);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : pvec_strm_if
`default_nettype wire

// ==== verif/pvec_src_model.sv ====
// stand-in for the sensor front controller and the sdram frame fetch
`timescale 1ns/1ps
`default_nettype none
module pvec_src_model
  import pvec_pkg::*;
(
  // clock
  input  wire logic             clk_sys_i,
  // video port pins
  output logic      [PIX_W-1:0] vp_pix_o,
  output logic                  vp_valid_o,
  output logic                  vp_line_o,
  output logic                  vp_frame_o,
  // sdram stream
  output logic      [PIX_W-1:0] sd_pix_o,
  output logic                  sd_valid_o,
  output logic                  sd_line_o,
  output logic                  sd_frame_o,
  input  wire logic             sd_ready_i
);
  // pixels of the next frame, filled by the bench
  logic [PIX_W-1:0] pix [64];
  logic             sel = 1'b0;
  logic             frm = 1'b0;
  logic             lin = 1'b0;
  logic             vld = 1'b0;
  logic [PIX_W-1:0] cur = '0;
  // only the chosen port moves; idle data shows the inverse
  assign vp_frame_o = frm & ~sel;
  assign vp_line_o  = lin & ~sel;
  assign vp_valid_o = vld & ~sel;
  assign vp_pix_o   = (vld & ~sel) ? cur : ~cur;
  assign sd_frame_o = frm & sel;
  assign sd_line_o  = lin & sel;
  assign sd_valid_o = vld & sel;
  assign sd_pix_o   = (vld & sel) ? cur : ~cur;
  // frame rise, lines of pixels, frame fall
  task automatic send_frame(input logic sd, input int nl, input int np);
    @(posedge clk_sys_i);
    sel <= sd;
    frm <= 1'b1;
    for (int l = 0; l < nl; l++) begin
      repeat (2) @(posedge clk_sys_i);
      lin <= 1'b1;
      // the line rise cycle carries no pixel
      @(posedge clk_sys_i);
      for (int p = 0; p < np; p++) begin
        cur <= pix[l*np+p];
        vld <= 1'b1;
        // sdram pixel held until taken
        do @(posedge clk_sys_i); while (sd && sd_ready_i !== 1'b1);
      end
      vld <= 1'b0;
      lin <= 1'b0;
    end
    repeat (2) @(posedge clk_sys_i);
    frm <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask : send_frame
endmodule : pvec_src_model
`default_nettype wire

// ==== verif/tb_pvec_ctrl.sv ====
// self-checking bench for the preview engine control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_pvec_ctrl
  import pvec_pkg::*;
;
  localparam int NL = 4;
  localparam int NP = 10;
  logic             clk_sys_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [3:0]       avs_address_i = 4'h0;
  logic             avs_read_i = 1'b0;
  logic             avs_write_i = 1'b0;
  logic [31:0]      avs_writedata_i = 32'h0;
  logic [3:0]       avs_byteenable_i = 4'hf;
  logic [31:0]      avs_readdata_o;
  logic             avs_waitrequest_o;
  logic [PIX_W-1:0] vp_pix_i, sd_pix_i, px_data_o;
  logic             vp_valid_i, vp_line_i, vp_frame_i, px_valid_o;
  logic             sd_valid_i, sd_line_i, sd_frame_i, sd_ready_o;
  logic             px_ready_i = 1'b0;
  logic             stall = 1'b0;
  logic [15:0]      lfsr = 16'h1;
  logic [15:0]      seed16 = 16'h1;
  // stage-a history and dark level, as the engine should hold them
  logic [PIX_W-1:0] h1 = '0;
  logic [PIX_W-1:0] h2 = '0;
  logic [PIX_W-1:0] dk = DARK_RST;
  logic [PIX_W-1:0] got [$];
  int               n_errors = 0;
  int               comparisons = 0;
  int               cyc = 0;

  // design and far side
  pvec_ctrl pvec_ctrl_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .vp_pix_i(vp_pix_i), .vp_valid_i(vp_valid_i), .vp_line_i(vp_line_i),
    .vp_frame_i(vp_frame_i), .sd_pix_i(sd_pix_i), .sd_valid_i(sd_valid_i),
    .sd_line_i(sd_line_i), .sd_frame_i(sd_frame_i), .sd_ready_o(sd_ready_o),
    .px_data_o(px_data_o), .px_valid_o(px_valid_o), .px_ready_i(px_ready_i)
  );
  pvec_src_model pvec_src_model_i (
    .clk_sys_i(clk_sys_i), .vp_pix_o(vp_pix_i), .vp_valid_o(vp_valid_i),
    .vp_line_o(vp_line_i), .vp_frame_o(vp_frame_i), .sd_pix_o(sd_pix_i),
    .sd_valid_o(sd_valid_i), .sd_line_o(sd_line_i),
    .sd_frame_o(sd_frame_i), .sd_ready_i(sd_ready_o)
  );

  // clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // sink back-pressure and output capture
  always @(posedge clk_sys_i) begin
    lfsr <= (cyc == 0) ? seed16
          : {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    px_ready_i <= ~stall & (lfsr[1:0] != 2'b00);
    if (px_valid_o === 1'b1 && px_ready_i === 1'b1) got.push_back(px_data_o);
  end

  // hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // width format, then a-law expansion of the eight-bit code
  function automatic logic [PIX_W-1:0] lin_of(input logic [PIX_W-1:0] p,
                                              input logic [31:0] c);
    logic [PIX_W-1:0] f;
    logic [14:0]      x;
    f = c[B_WIDTH] ? {p[7:0], 2'b00} : p;
    x = 15'({1'b1, f[6:2]}) << f[9:7];
    return c[B_ALAW] ? x[14:5] : f;
  endfunction : lin_of

  // noise, interpolation and median stage against the history
  function automatic logic [PIX_W-1:0] filt(input logic [PIX_W-1:0] a,
                                            input logic [31:0] c);
    logic [PIX_W:0]   s1, s2;
    logic [PIX_W-1:0] nf, cf, lo, hi, mh, md;
    s1 = {1'b0, a} + {1'b0, h1};
    s2 = {1'b0, a} + {1'b0, h2};
    nf = c[B_NOISE] ? s1[PIX_W:1] : a;
    cf = c[B_CFA] ? s2[PIX_W:1] : nf;
    lo = (cf < h1) ? cf : h1;
    hi = (cf < h1) ? h1 : cf;
    mh = (hi < h2) ? hi : h2;
    md = (lo > mh) ? lo : mh;
    return c[B_MEDIAN] ? md : cf;
  endfunction : filt

  // one frame through the engine, checked against the window
  task automatic frame(input logic [31:0] ctl, input logic wc,
                       input logic bsy);
    logic [31:0]      q;
    logic [PIX_W-1:0] exp [$];
    logic [PIX_W-1:0] a;
    logic             sd;
    int               sp, ep, sl, el, n;
    sd = ctl[B_SOURCE];
    sp = sd ? 0 : $urandom_range(2, 4);
    ep = sd ? NP - 1 : $urandom_range(sp, NP - 3);
    // lines count from one: the first line rise after frame start
    sl = sd ? 1 : $urandom_range(1, 2);
    el = sd ? NL : $urandom_range(sl, NL);
    wr(OFS_HORZ, {2'h0, 14'(sp), 2'h0, 14'(ep)});
    wr(OFS_VERT, {2'h0, 14'(sl), 2'h0, 14'(el)});
    if (wc) wr(OFS_CTRL, ctl);
    for (n = 0; n < NL * NP; n++) begin
      pvec_src_model_i.pix[n] = PIX_W'($urandom_range(0, 1023));
      if (ctl[B_ENABLE] && n / NP + 1 >= sl && n / NP + 1 <= el &&
          n % NP >= sp && n % NP <= ep) begin
        a = lin_of(pvec_src_model_i.pix[n], ctl);
        if (ctl[B_DCAP]) begin
          dk = a;
        end else begin
          if (ctl[B_DSUB]) a = (a > dk) ? a - dk : '0;
          exp.push_back(filt(a, ctl));
          h2 = h1;
          h1 = a;
        end
      end
    end
    got.delete();
    fork
      pvec_src_model_i.send_frame(sd, NL, NP);
      begin
        logic [31:0] r;
        repeat (20) @(posedge clk_sys_i);
        bus(1'b0, OFS_CTRL, 32'h0, r);
        `CHK(r[B_BUSY], bsy)
      end
      if (sd) begin
        int k;
        stall <= 1'b1;
        for (k = 0; k < 300 && sd_ready_o !== 1'b0; k++) @(posedge clk_sys_i);
        `CHK(sd_ready_o, 1'b0)
        repeat (4) @(posedge clk_sys_i);
        stall <= 1'b0;
      end
    join
    for (n = 0; n < 400 && got.size() < exp.size(); n++) @(posedge clk_sys_i);
    repeat (10) @(posedge clk_sys_i);
    `CHK(got.size(), exp.size())
    for (n = 0; n < exp.size() && n < got.size(); n++)
      `CHK(got[n], exp[n])
    `CHK(px_valid_o, 1'b0)
    bus(1'b0, OFS_CTRL, 32'h0, q);
    `CHK(q[B_BUSY], 1'b0)
  endtask : frame

  // main sequence
  initial begin
    logic [31:0] q;
    logic [31:0] c;
    void'($urandom(32'h8c7f84e6));
    seed16 = 16'($urandom) | 16'h1;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped place included
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 4'(a), 32'h0, q);
      `CHK(q, 32'h0)
    end
    wr(OFS_HORZ, 32'hffff_ffff);
    bus(1'b0, OFS_HORZ, 32'h0, q);
    `CHK(q, 32'h3fff_3fff)
    avs_byteenable_i <= 4'h1;
    wr(OFS_HORZ, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, OFS_HORZ, 32'h0, q);
    `CHK(q, 32'h3fff_3f00)
    wr(OFS_VERT, 32'hffff_ffff);
    bus(1'b0, OFS_VERT, 32'h0, q);
    `CHK(q, 32'h3fff_3fff)
    // enable write clears one-shot and source
    wr(OFS_CTRL, 32'hffff_ffff);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    `CHK(q, 32'h0000_07f1)
    wr(OFS_CTRL, 32'h0000_000c);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    `CHK(q, 32'h0000_000c)
    // video port runs, continuous, both widths
    c = 32'h1 | (32'($urandom_range(0, 1)) << B_WIDTH);
    frame(c, 1'b1, 1'b1);
    frame(c, 1'b0, 1'b1);
    frame(c ^ (32'h1 << B_WIDTH), 1'b1, 1'b1);
    // dark capture and disabled runs drop pixels
    frame(32'h0000_0081, 1'b1, 1'b1);
    frame(32'h0000_0000, 1'b1, 1'b0);
    // all filters, a-law on narrow input, dark level subtracted
    frame(32'h0000_0771, 1'b1, 1'b1);
    // one-shot sdram run with a full buffer
    frame(32'h0000_000d, 1'b1, 1'b1);
    bus(1'b0, OFS_CTRL, 32'h0, q);
    `CHK(q, 32'h0)
    summarize();
  end
endmodule : tb_pvec_ctrl
`default_nettype wire
